/* rtl/pinirq_defs.svh */
// Offsets, field positions, widths and response codes of the pin interrupt and indicator block.
`ifndef PINIRQ_DEFS_SVH
`define PINIRQ_DEFS_SVH
`define PI_NPINS 12
`define PI_NLED 8
`define PI_OFS_LED_CFG 12'h1BC
`define PI_OFS_IRQ_STS_EN 12'h1E8
`define PI_OFS_DIR 12'h1E4
`define PI_OFS_TOP_STS 12'h1F0
`define PI_OFS_TOP_MASK 12'h1F4
`define PI_ADDR_W 12
`define PI_EN_LSB 16
`define PI_EN_MSB 27
`define PI_FUN_LSB 8
`define PI_FUN_MSB 9
`define PI_TOP_PIN_BIT 4'hC
`define PI_TOP_MSB 12
`define PI_RESP_OKAY 2'h0
`define PI_RESP_SLVERR 2'h2
`define PI_ZERO12 12'h000
`define PI_ZERO32 32'h00000000
`endif

/* rtl/pinirq_pkg.sv */
// Types shared by the pin interrupt and indicator block.
`include "pinirq_defs.svh"
package pinirq_pkg;
  typedef logic [`PI_NPINS-1:0] pinirq_pins_t;
  typedef logic [`PI_NLED-1:0] pinirq_led_t;
  typedef logic [1:0] pinirq_fun_t;
  typedef logic [`PI_ADDR_W-1:0] pinirq_addr_t;
endpackage : pinirq_pkg

/* rtl/pinirq_sync.sv */
// Two-flop synchroniser for the pin inputs and the external reset strap trigger.
`timescale 1ns/1ns
module pinirq_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pinirq_sync_s;
  pinirq_sync_s st_q, st_d;
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s2;
endmodule : pinirq_sync

/* rtl/pinirq_flags.sv */
// Sticky per-pin interrupt flags with write-one-to-clear.
`timescale 1ns/1ns
`include "pinirq_defs.svh"
module pinirq_flags (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pinirq_pkg::pinirq_pins_t cond,
  input wire pinirq_pkg::pinirq_pins_t clr,
  output pinirq_pkg::pinirq_pins_t flags
);
  import pinirq_pkg::*;
  typedef struct packed {
    pinirq_pins_t f;
  } pinirq_flags_s;
  pinirq_flags_s st_q, st_d;
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < `PI_NPINS; i++) begin
      // A live condition wins over a clear in the same cycle so no event is lost.
      st_d.f[i] = cond[i] | (st_q.f[i] & ~clr[i]); // R1 R4 R12
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign flags = st_q.f;
endmodule : pinirq_flags

/* rtl/pinirq_top.sv */
// Pin interrupt status/enable and indicator configuration block behind an AXI4-Lite slave.
// What this block does
// [R1] Writing 1 to a pin status bit clears it; writing 0 leaves it.
// [R2] OR of enabled pin flags drives bit 12 of top interrupt status.
// [R3] Twelve R/W pin interrupt enables in bits 27:16, reset to zero.
// [R4] Pin flags in bits 11:0 follow sources regardless of enables; reset zero.
// [R5] Host interrupt asserts for pins only when bit 12 status and mask set.
// [R6] Outside sources hold interrupt level above 40 ns; inputs are level sensitive.
// [R7] Indicator enable bits 7:0: 0 keeps pin as I/O, 1 makes LED.
// [R8] Indicator function bits 9:8 pick LED behaviour for enabled pins only.
// [R9] Indicator field reset values come from straps latched at reset release.
// [R10] Configuration loader may replace latched strap values afterwards as defaults.
// [R11] Direction bits 27:16 make pins input (0) or output (1).
// [R12] Pin inputs are synchronised; flags stay set until cleared or condition persists.
`timescale 1ns/1ns
`include "pinirq_defs.svh"
module pinirq_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic external_reset_n,
  input wire pinirq_pkg::pinirq_led_t led_en_strap,
  input wire pinirq_pkg::pinirq_fun_t led_fun_strap,
  input wire logic loader_valid,
  input wire pinirq_pkg::pinirq_led_t loader_led_en,
  input wire pinirq_pkg::pinirq_fun_t loader_led_fun,
  input wire pinirq_pkg::pinirq_pins_t pin_in,
  output pinirq_pkg::pinirq_pins_t pin_direction,
  output pinirq_pkg::pinirq_led_t led_select,
  output pinirq_pkg::pinirq_fun_t led_function,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pinirq_pkg::*;

  typedef struct packed {
    logic aw_got;
    pinirq_addr_t aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    pinirq_pins_t irq_en;
    pinirq_pins_t dir;
    pinirq_led_t led_en;
    pinirq_fun_t led_fun;
    pinirq_led_t def_en;
    pinirq_fun_t def_fun;
    logic strap_armed;
    logic ext_rst_prev;
    logic top_sts;
    logic top_mask;
    logic irq;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    pinirq_fun_t fun_out;
  } pinirq_top_s;

  pinirq_top_s st_q, st_d;
  pinirq_pins_t pin_sync;
  logic ext_rst_act;
  logic strap_take;
  logic aw_mapped;
  pinirq_pins_t flags;
  pinirq_pins_t clr;
  logic wr_fire;
  logic rd_fire;
  pinirq_addr_t rd_addr;
  logic pin_event;

  // Pin inputs come from the package pins and must be retimed before any logic sees them.
  pinirq_sync #(.W(`PI_NPINS)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_in),
    .q(pin_sync)
  ); // R12

  // The reset pin is retimed inverted, so the cleared synchroniser matches an idle pin.
  // Otherwise the first cycles after reset would look like a release and recapture the straps.
  pinirq_sync #(.W(1)) u_rst_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(~external_reset_n),
    .q(ext_rst_act)
  );

  pinirq_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .cond(pin_sync & ~st_q.dir), // R11 R6
    .clr(clr),
    .flags(flags)
  );

  assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign rd_fire = s_axi_arvalid && !st_q.rvalid;
  assign rd_addr = s_axi_araddr[`PI_ADDR_W-1:0];
  assign clr = (wr_fire && st_q.aw_addr == `PI_OFS_IRQ_STS_EN && st_q.w_strb[0] && st_q.w_strb[1])
      ? st_q.w_data[`PI_NPINS-1:0] : `PI_ZERO12; // R1
  assign pin_event = |(flags & st_q.irq_en); // R2
  // Straps are taken on the first edge out of reset and whenever the external reset releases.
  assign strap_take = st_q.strap_armed || (st_q.ext_rst_prev && !ext_rst_act); // R9
  assign aw_mapped = (st_q.aw_addr == `PI_OFS_IRQ_STS_EN) || (st_q.aw_addr == `PI_OFS_DIR)
      || (st_q.aw_addr == `PI_OFS_LED_CFG) || (st_q.aw_addr == `PI_OFS_TOP_STS)
      || (st_q.aw_addr == `PI_OFS_TOP_MASK);

  always_comb begin
    st_d = st_q;
    // Write address and data may arrive in either order; each is held until both are here.
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr[`PI_ADDR_W-1:0];
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Straps are recaptured when the synchronised external reset is released.
    st_d.ext_rst_prev = ext_rst_act;
    if (strap_take) begin
      st_d.strap_armed = 1'b0;
      st_d.def_en = led_en_strap; // R9
      st_d.def_fun = led_fun_strap; // R9
      st_d.led_en = led_en_strap; // R9
      st_d.led_fun = led_fun_strap; // R9
    end
    if (loader_valid) begin
      st_d.def_en = loader_led_en; // R10
      st_d.def_fun = loader_led_fun; // R10
      st_d.led_en = loader_led_en; // R10
      st_d.led_fun = loader_led_fun; // R10
    end
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = `PI_RESP_OKAY;
      unique case (st_q.aw_addr)
        `PI_OFS_IRQ_STS_EN: begin
          if (st_q.w_strb[2] && st_q.w_strb[3]) begin
            st_d.irq_en = st_q.w_data[`PI_EN_MSB:`PI_EN_LSB]; // R3
          end
        end
        `PI_OFS_DIR: begin
          if (st_q.w_strb[2] && st_q.w_strb[3]) begin
            st_d.dir = st_q.w_data[`PI_EN_MSB:`PI_EN_LSB]; // R11
          end
        end
        `PI_OFS_LED_CFG: begin
          if (st_q.w_strb[0]) begin
            st_d.led_en = st_q.w_data[`PI_NLED-1:0]; // R7
          end
          if (st_q.w_strb[1]) begin
            st_d.led_fun = st_q.w_data[`PI_FUN_MSB:`PI_FUN_LSB]; // R8
          end
        end
        `PI_OFS_TOP_MASK: begin
          if (st_q.w_strb[1]) begin
            st_d.top_mask = st_q.w_data[`PI_TOP_MSB];
          end
        end
        `PI_OFS_TOP_STS: begin
        end
        default: begin
          st_d.bresp = `PI_RESP_SLVERR;
        end
      endcase
    end
    // Top status is sticky; an event in the same cycle as a read survives the clear.
    if (rd_fire && rd_addr == `PI_OFS_TOP_STS) begin
      st_d.top_sts = 1'b0;
    end
    if (pin_event) begin
      st_d.top_sts = 1'b1; // R2
    end
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `PI_RESP_OKAY;
      st_d.rdata = `PI_ZERO32;
      unique case (rd_addr)
        `PI_OFS_IRQ_STS_EN: begin
          st_d.rdata[`PI_EN_MSB:`PI_EN_LSB] = st_q.irq_en;
          st_d.rdata[`PI_NPINS-1:0] = flags;
        end
        `PI_OFS_DIR: begin
          st_d.rdata[`PI_EN_MSB:`PI_EN_LSB] = st_q.dir;
          st_d.rdata[`PI_NPINS-1:0] = pin_sync;
        end
        `PI_OFS_LED_CFG: begin
          st_d.rdata[`PI_FUN_MSB:`PI_FUN_LSB] = st_q.led_fun;
          st_d.rdata[`PI_NLED-1:0] = st_q.led_en;
        end
        `PI_OFS_TOP_STS: begin
          st_d.rdata[`PI_TOP_MSB] = st_q.top_sts;
        end
        `PI_OFS_TOP_MASK: begin
          st_d.rdata[`PI_TOP_MSB] = st_q.top_mask;
        end
        default: begin
          st_d.rresp = `PI_RESP_SLVERR;
        end
      endcase
    end
    st_d.irq = st_d.top_sts && st_d.top_mask; // R5
    // Readies and the gated function are kept as flops so that every port leaves a register.
    st_d.aw_rdy = !st_d.aw_got;
    st_d.w_rdy = !st_d.w_got;
    st_d.ar_rdy = !st_d.rvalid;
    st_d.fun_out = (|st_d.led_en) ? st_d.led_fun : 2'h0; // R8
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.strap_armed <= 1'b1;
      st_q.aw_rdy <= 1'b1;
      st_q.w_rdy <= 1'b1;
      st_q.ar_rdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.aw_rdy;
  assign s_axi_wready = st_q.w_rdy;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.ar_rdy;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign pin_direction = st_q.dir;
  // The function field is only meaningful to pins whose indicator enable is set.
  assign led_select = st_q.led_en; // R7
  assign led_function = st_q.fun_out; // R8
  assign irq = st_q.irq;

  // Pin figures below are counted after the synchroniser, one cycle before the flag.
  sticky_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      (pin_sync[0] && !st_q.dir[0]) |=> flags[0]) else $error("flag missed live pin");
  clear_works_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
      (clr[3] && !(pin_sync[3] && !st_q.dir[3])) |=> !flags[3]) else $error("w1c failed");
  flag_holds_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      (flags[5] && !clr[5]) |=> flags[5]) else $error("flag dropped");
  top_cascade_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      pin_event |=> st_q.top_sts) else $error("cascade lost");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      irq |-> (st_q.top_sts && st_q.top_mask)) else $error("irq without cause");
  enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      (wr_fire && st_q.aw_addr == `PI_OFS_IRQ_STS_EN && &st_q.w_strb)
      |=> st_q.irq_en == $past(st_q.w_data[`PI_EN_MSB:`PI_EN_LSB])) else $error("enable");
  dir_masks_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      (st_q.dir[2] && !flags[2] && !clr[2]) |=> !flags[2]) else $error("output pin flagged");
  led_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      (wr_fire && st_q.aw_addr == `PI_OFS_LED_CFG && st_q.w_strb[0] && !loader_valid
      && !strap_take) |=> led_select == $past(st_q.w_data[`PI_NLED-1:0]))
      else $error("led enable");
  loader_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
      loader_valid |=> st_q.def_en == $past(loader_led_en)) else $error("loader");
  strap_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
      (st_q.strap_armed && !loader_valid) |=> led_select == $past(led_en_strap))
      else $error("strap");
  fun_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      !(|led_select) |-> led_function == 2'h0) else $error("fun ungated");
  fun_pass_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      (|led_select) |-> led_function == st_q.led_fun) else $error("fun not passed");
  strap_take_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
      (strap_take && !loader_valid) |=> (st_q.def_fun == $past(led_fun_strap)
      && st_q.def_en == $past(led_en_strap))) else $error("strap not latched");
  loader_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
      (loader_valid && strap_take) |=> led_select == $past(loader_led_en)) else $error("loader lost");
  dir_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      (wr_fire && st_q.aw_addr == `PI_OFS_DIR && &st_q.w_strb)
      |=> pin_direction == $past(st_q.w_data[`PI_EN_MSB:`PI_EN_LSB])) else $error("direction");
  mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      (wr_fire && st_q.aw_addr == `PI_OFS_TOP_MASK && st_q.w_strb[1])
      |=> st_q.top_mask == $past(st_q.w_data[`PI_TOP_MSB])) else $error("mask write");
  status_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3 R4
      (rd_fire && rd_addr == `PI_OFS_IRQ_STS_EN) |=> (s_axi_rdata[`PI_NPINS-1:0] == $past(flags)
      && s_axi_rdata[`PI_EN_MSB:`PI_EN_LSB] == $past(st_q.irq_en))) else $error("status read");
  led_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7 R8
      (rd_fire && rd_addr == `PI_OFS_LED_CFG)
      |=> (s_axi_rdata[`PI_NLED-1:0] == $past(st_q.led_en)
      && s_axi_rdata[`PI_FUN_MSB:`PI_FUN_LSB] == $past(st_q.led_fun))) else $error("led read");
  top_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      (rd_fire && rd_addr == `PI_OFS_TOP_STS && !pin_event) |=> !st_q.top_sts)
      else $error("top status not cleared");
  top_set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      (rd_fire && rd_addr == `PI_OFS_TOP_STS && pin_event) |=> st_q.top_sts)
      else $error("top status event lost");
  // Bus answers stand with their payload until the master takes them.
  bresp_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write answer dropped");
  rdata_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))) else $error("read answer dropped");
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid) else $error("no write answer");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("no read answer");
  aw_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready) else $error("address taken twice");
  map_error_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && !aw_mapped) |=> (s_axi_bresp == `PI_RESP_SLVERR))
      else $error("unmapped write answered okay");
  map_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && aw_mapped) |=> (s_axi_bresp == `PI_RESP_OKAY))
      else $error("mapped write refused");
  cov_irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  cov_clear_c: cover property (@(posedge aclk) disable iff (!aresetn) flags[0] ##1 !flags[0]);
  cov_led_c: cover property (@(posedge aclk) disable iff (!aresetn) |led_select);
  cov_strap_c: cover property (@(posedge aclk) disable iff (!aresetn)
      st_q.ext_rst_prev && !ext_rst_act);
  cov_slverr_c: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bresp == `PI_RESP_SLVERR);
endmodule : pinirq_top

/* verification/pinirq_pin_model.sv */
// External pin sources that raise interrupt levels on the pin inputs.
`timescale 1ns/1ns
module pinirq_pin_model #(
  parameter int HOLD = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  input wire pinirq_pkg::pinirq_pins_t pattern,
  output pinirq_pkg::pinirq_pins_t pin_in
);
  import pinirq_pkg::*;
  // Twelve cycles of 4 ns keeps the level active for longer than 40 ns.
  int cnt_q;
  pinirq_pins_t pin_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 0;
      pin_q <= '0;
    end else if (fire) begin
      cnt_q <= HOLD;
      pin_q <= pattern;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) begin
        pin_q <= '0;
      end
    end
  end
  assign pin_in = pin_q;
endmodule : pinirq_pin_model

/* verification/pin_irq_and_led_select_tb.sv */
// Self-checking bench for the pin interrupt and indicator block.
`timescale 1ns/1ns
`include "pinirq_defs.svh"
module pin_irq_and_led_select_tb;
  import pinirq_pkg::*;
  logic aclk, aresetn, external_reset_n, loader_valid, fire, irq;
  pinirq_led_t led_en_strap, loader_led_en, led_select, en;
  pinirq_fun_t led_fun_strap, loader_led_fun, led_function, fn;
  pinirq_pins_t pin_in, pin_direction, pattern, dir;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int k, j;
  pinirq_top i_pinirq_top (.aclk(aclk), .aresetn(aresetn), .external_reset_n(external_reset_n),
    .led_en_strap(led_en_strap), .led_fun_strap(led_fun_strap), .loader_valid(loader_valid),
    .loader_led_en(loader_led_en), .loader_led_fun(loader_led_fun), .pin_in(pin_in),
    .pin_direction(pin_direction), .led_select(led_select), .led_function(led_function),
    .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  pinirq_pin_model i_pinirq_pin_model (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .pattern(pattern), .pin_in(pin_in));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Bready and rready stay high, so every answer is taken at the edge it appears.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {20'h00000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr
  task automatic rdt(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {20'h00000, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rdt
  function automatic logic [31:0] led_cfg(input pinirq_led_t e, input pinirq_fun_t f);
    return {22'h0, f, e};
  endfunction : led_cfg
  function automatic pinirq_fun_t fun_out(input pinirq_led_t e, input pinirq_fun_t f);
    return (e == 8'h00) ? 2'h0 : f;
  endfunction : fun_out
  initial begin
    void'($urandom(46979));
    {aresetn, loader_valid, fire, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {external_reset_n, s_axi_bready, s_axi_rready} = 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, pattern} = '0;
    s_axi_wstrb = 4'hF;
    {loader_led_en, loader_led_fun} = '0;
    {led_en_strap, led_fun_strap} = 10'($urandom);
    cyc(10);
    aresetn <= 1'b1;
    cyc(2);
    rdt(`PI_OFS_IRQ_STS_EN, rd, rs);
    chk(rd, 32'h00000000);
    rdt(`PI_OFS_LED_CFG, rd, rs);
    chk(rd, led_cfg(led_en_strap, led_fun_strap));
    chk(32'(led_select), 32'(led_en_strap));
    {led_en_strap, led_fun_strap} <= 10'($urandom);
    external_reset_n <= 1'b0;
    cyc(4);
    external_reset_n <= 1'b1;
    cyc(6);
    rdt(`PI_OFS_LED_CFG, rd, rs);
    chk(rd, led_cfg(led_en_strap, led_fun_strap));
    {loader_led_en, loader_led_fun} <= 10'($urandom);
    loader_valid <= 1'b1;
    cyc(1);
    loader_valid <= 1'b0;
    cyc(3);
    rdt(`PI_OFS_LED_CFG, rd, rs);
    chk(rd, led_cfg(loader_led_en, loader_led_fun));
    for (int i = 0; i < 2; i++) begin
      en = (i == 0) ? 8'h00 : 8'($urandom);
      fn = 2'($urandom);
      wr(`PI_OFS_LED_CFG, led_cfg(en, fn), rs);
      cyc(2);
      chk(32'(led_select), 32'(en));
      chk(32'(led_function), 32'(fun_out(en, fn)));
    end
    k = $urandom_range(11, 0);
    j = (k + 1 + $urandom_range(10, 0)) % 12;
    dir = 12'($urandom);
    dir[k] = 1'b0;
    dir[j] = 1'b1;
    wr(`PI_OFS_DIR, {4'h0, dir, 16'h0000}, rs);
    cyc(2);
    chk(32'(pin_direction), 32'(dir));
    wr(`PI_OFS_TOP_MASK, 32'h00000000, rs);
    pattern <= (12'h001 << k) | (12'h001 << j);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    cyc(20);
    // The pin has been released by now, so the flag must be holding on its own.
    rdt(`PI_OFS_IRQ_STS_EN, rd, rs);
    chk(rd, 32'h00000001 << k);
    rdt(`PI_OFS_TOP_STS, rd, rs);
    chk(rd, 32'h00000000);
    wr(`PI_OFS_IRQ_STS_EN, 32'h00010000 << k, rs);
    rdt(`PI_OFS_IRQ_STS_EN, rd, rs);
    chk(rd, (32'h00010000 << k) | (32'h00000001 << k));
    cyc(3);
    rdt(`PI_OFS_TOP_STS, rd, rs);
    chk(rd, 32'h00001000);
    cyc(3);
    chk(32'(irq), 32'h00000000);
    wr(`PI_OFS_TOP_MASK, 32'h00001000, rs);
    cyc(3);
    chk(32'(irq), 32'h00000001);
    wr(`PI_OFS_IRQ_STS_EN, (32'h00010000 << k) | (32'h00000001 << k), rs);
    rdt(`PI_OFS_IRQ_STS_EN, rd, rs);
    chk(rd, 32'h00010000 << k);
    rdt(`PI_OFS_TOP_STS, rd, rs);
    chk(rd, 32'h00001000);
    rdt(`PI_OFS_TOP_STS, rd, rs);
    chk(rd, 32'h00000000);
    cyc(3);
    chk(32'(irq), 32'h00000000);
    wr(12'h100, 32'h00000000, rs);
    chk(32'(rs), 32'(`PI_RESP_SLVERR));
    rdt(12'h100, rd, rs);
    chk(32'(rs), 32'(`PI_RESP_SLVERR));
    results();
  end
endmodule : pin_irq_and_led_select_tb
